// File: hdl/pfs_cfg.svh
// constants of the protection fault supervisor: offsets, fields, resets and timings
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// -----------------------------------------------------------------
// clock and time conversion
// -----------------------------------------------------------------
`define PFS_CLK_HZ 10000000
// least times round up to whole cycles
`define PFS_US2CYC(us) ((((us) * (`PFS_CLK_HZ / 1000)) + 999) / 1000)
`define PFS_MS2CYC(ms) ((ms) * (`PFS_CLK_HZ / 1000))

// -----------------------------------------------------------------
// debounce and retry times, in their own units
// -----------------------------------------------------------------
`define PFS_OUT_UV_DEB_MS 16
`define PFS_PREBIAS_DEB_US 10
`define PFS_CS_OCL_DEB_US 400
`define PFS_CS_OCH_DEB_US 5
`define PFS_PRESENT_DEB_US 30
`define PFS_STG_LOW_MS 8
`define PFS_STG_RETRY_MS 16
`define PFS_INPUT_UNDERVOLT_FLAG_DEB_US 100
`define PFS_SHLD_THR_DEB_US 5
`define PFS_SHLD_SLOPE_DEB_US 2
`define PFS_INPUT_OVERCURRENT_FLAG_DEB_MS 16
`define PFS_RETRY_UNIT_MS 1
`define PFS_B_RETRY_MS 1

// -----------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------
`define PFS_OFS_STATUS 8'h00
`define PFS_OFS_FSTAT 8'h04
`define PFS_OFS_FMASK 8'h08
`define PFS_OFS_CTRL 8'h0c
`define PFS_OFS_ALERT 8'h10
`define PFS_OFS_CMD 8'h14

// -----------------------------------------------------------------
// status register bit positions
// -----------------------------------------------------------------
`define PFS_ST_OUT_UV 0
`define PFS_ST_OUT_STG 1
`define PFS_ST_HOST_ERR 2
`define PFS_ST_CS_OCL 3
`define PFS_ST_CS_OCF 4
`define PFS_ST_CS_UV 5
`define PFS_ST_CS_REV 6
`define PFS_ST_INPUT_UNDERVOLT_FLAG 7
`define PFS_ST_SHIELD 8
`define PFS_ST_INPUT_OVERCURRENT_FLAG 9
`define PFS_ST_RUNAWAY 10
`define PFS_ST_SUMMARY 11
`define PFS_ST_VENDOR 12

// fault status bit positions
`define PFS_FS_HOST_ERR 0
`define PFS_FS_CS_OCF 1

// control register fields
`define PFS_CT_CL_MODE 0
`define PFS_CT_SUM_MASK 1
`define PFS_CT_SW_EN 2
`define PFS_CT_OUV_LO 4
`define PFS_CT_OUV_HI 6
`define PFS_CT_IUV_LO 8
`define PFS_CT_IUV_HI 11
`define PFS_CT_RTY_LO 12
`define PFS_CT_RTY_HI 15
`define PFS_CT_PIN_LO 16
`define PFS_CT_PIN_HI 17

// alert register fields
`define PFS_AL_VENDOR 0
`define PFS_AL_FSTAT 1
`define PFS_AL_PRESENT 8
`define PFS_AL_CLOSED 9
`define PFS_AL_RETRY 10
`define PFS_AL_ACT_LO 12
`define PFS_AL_ACT_HI 14

// command bits
`define PFS_CMD_SRC_DEF 0
`define PFS_CMD_CONV_EN 1

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define PFS_RST_CTRL 18'h30002
`define PFS_RST_FMASK 8'hff

`endif

// File: hdl/pfs_pkg.sv
// types shared by the protection fault supervisor
package pfs_pkg;
   // action type taken for the most recent fault
   typedef enum logic [2:0] {
      ACT_NONE = 3'h0,
      ACT_A = 3'h1,
      ACT_B = 3'h2,
      ACT_C = 3'h3,
      ACT_D = 3'h4
   } pfs_action_t;

   // consecutive cable-supply overcurrent count, gray coded
   typedef enum logic [1:0] {
      OC_NONE = 2'b00,
      OC_ONE = 2'b01,
      OC_TWO = 2'b11
   } pfs_oc_cnt_t;
endpackage

// File: hdl/pfs_debounce.sv
// synchroniser and restartable debounce timer for one fault condition
module pfs_debounce #(
   parameter int CYC = 1,
   parameter bit SYNC = 1'b1,
   parameter int CW = 18
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic raw,
   input wire logic gate,
   output logic qual,
   output logic rise
);
   logic s1, s2, s3; // three-stage synchroniser
   logic lvl, next_lvl; // filtered level
   logic [CW-1:0] cnt, next_cnt; // time the condition has held
   logic next_qual, next_rise;
   logic cond;

   // -----------------------------------------------------------------
   // next values
   // -----------------------------------------------------------------
   always_comb begin
      // a level change counts only once the last two stages agree
      next_lvl = (s2 == s3) ? s3 : lvl;
      cond = (SYNC ? lvl : raw) & gate;
      // any drop restarts the window from zero
      if (!cond) begin
         next_cnt = '0;
      end else if (cnt >= CW'(CYC)) begin
         next_cnt = cnt;
      end else begin
         next_cnt = cnt + 1'b1;
      end
      next_qual = cond && (cnt >= CW'(CYC));
      next_rise = next_qual & ~qual;
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         lvl <= 1'b0;
         cnt <= '0;
         qual <= 1'b0;
         rise <= 1'b0;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         lvl <= next_lvl;
         cnt <= next_cnt;
         qual <= next_qual;
         rise <= next_rise;
      end
   end
endmodule

// File: hdl/pfs_retry.sv
// one-shot retry timer that holds the cable-supply switch open
module pfs_retry #(
   parameter int LW = 24
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [LW-1:0] len,
   output logic busy
);
   logic [LW-1:0] cnt, next_cnt; // cycles left open
   logic next_busy;

   // -----------------------------------------------------------------
   // next values: a new start reloads, so the latest fault sets the time
   // -----------------------------------------------------------------
   always_comb begin
      if (start) begin
         next_cnt = len;
      end else if (cnt != '0) begin
         next_cnt = cnt - 1'b1;
      end else begin
         next_cnt = cnt;
      end
      next_busy = (next_cnt != '0);
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt <= '0;
         busy <= 1'b0;
      end else begin
         cnt <= next_cnt;
         busy <= next_busy;
      end
   end
endmodule

// File: hdl/pfs_top.sv
// protection fault supervisor: debounce, flags, alerts and fault actions
//
// Added by the designer: the placing of the registers and the strobed register port.
`include "pfs_cfg.svh"

// How it works
// - output undervolt: 16ms debounce, flag, type C
// - current-limit mode: undervolt suppressed only off/soft-start
// - in current-limit regulation, undervolt does nothing
// - short-to-ground level follows mode; immediate, type A
// - default-voltage command above safe zero: error
// - low cable overcurrent 400us: type B
// - high cable overcurrent 5us: type B
// - overcurrent flags only on third consecutive fault
// - cable undervolt immediate; extra flags when enabled
// - reverse voltage immediate: flag, summary, type D
// - config line low 8ms: disable, D, 16ms
// - input undervolt 100us: flag, summary, type A
// - shield short: 5us/2us, type A, FET off
// - input overcurrent 16ms: flag, summary, type C
// - runaway immediate: flag, summary, type A
// - fault alert only when cause mask set
// - masked alert visible but pin not driven
// - type A: disable, open switches, discharge, retry
// - type D: open cable switch for retry time
// - type C alert only; port logic untouched
module pfs_top #(
   parameter int OUT_UV_DEB_CYC = `PFS_MS2CYC(`PFS_OUT_UV_DEB_MS),
   parameter int INPUT_OVERCURRENT_FLAG_DEB_CYC = `PFS_MS2CYC(`PFS_INPUT_OVERCURRENT_FLAG_DEB_MS),
   parameter int STG_LOW_CYC = `PFS_MS2CYC(`PFS_STG_LOW_MS),
   parameter int STG_RETRY_CYC = `PFS_MS2CYC(`PFS_STG_RETRY_MS),
   parameter int RETRY_UNIT_CYC = `PFS_MS2CYC(`PFS_RETRY_UNIT_MS),
   parameter int B_RETRY_CYC = `PFS_MS2CYC(`PFS_B_RETRY_MS)
) (
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // comparator inputs, asynchronous
   input wire logic outUvCmp,
   input wire logic outStgCmp,
   input wire logic outAboveSafe0Cmp,
   input wire logic csOcLowCmp,
   input wire logic csOcHighCmp,
   input wire logic csFastUvCmp,
   input wire logic csReverseCmp,
   input wire logic cfgLineLowCmp,
   input wire logic inUvCmp,
   input wire logic shieldThreshCmp,
   input wire logic shieldSlopeCmp,
   input wire logic inOcCmp,
   input wire logic outBelowHalfCmp,
   input wire logic outCurrentOverCmp,
   // converter state, same clock
   input wire logic outOff,
   input wire logic outSoftStart,
   input wire logic outTransition,
   input wire logic in_current_limit_regulation,
   // analog threshold selects
   output logic [2:0] output_undervolt_level_sel,
   output logic [3:0] input_undervolt_level_sel,
   output logic stgLevelHigh,
   // actions
   output logic convDisable,
   output logic dataSwitchOpen,
   output logic passSwitchOpen,
   output logic cfgLineDischarge,
   output logic chargerDetReset,
   output logic shieldFetOff,
   output logic cableSwitchClose,
   // open-drain alert pin, active low
   output logic alertN_out,
   output logic alertN_oe
);
   localparam int N = 14; // debounced conditions
   localparam int LW = 24; // retry length width
   // condition indices
   localparam int I_OUV = 0, I_STG = 1, I_PRE = 2, I_OCL = 3, I_OCH = 4, I_CUV = 5;
   localparam int I_REV = 6, I_PRS = 7, I_CSTG = 8, I_IUV = 9, I_SHT = 10, I_SHS = 11;
   localparam int I_IOC = 12, I_RNA = 13;

   // debounce time of each condition
   function automatic int deb_cyc(input int i);
      case (i)
         I_OUV: deb_cyc = OUT_UV_DEB_CYC;
         I_PRE: deb_cyc = `PFS_US2CYC(`PFS_PREBIAS_DEB_US);
         I_OCL: deb_cyc = `PFS_US2CYC(`PFS_CS_OCL_DEB_US);
         I_OCH: deb_cyc = `PFS_US2CYC(`PFS_CS_OCH_DEB_US);
         I_PRS: deb_cyc = `PFS_US2CYC(`PFS_PRESENT_DEB_US);
         I_CSTG: deb_cyc = STG_LOW_CYC;
         I_IUV: deb_cyc = `PFS_US2CYC(`PFS_INPUT_UNDERVOLT_FLAG_DEB_US);
         I_SHT: deb_cyc = `PFS_US2CYC(`PFS_SHLD_THR_DEB_US);
         I_SHS: deb_cyc = `PFS_US2CYC(`PFS_SHLD_SLOPE_DEB_US);
         I_IOC: deb_cyc = INPUT_OVERCURRENT_FLAG_DEB_CYC;
         default: deb_cyc = 0; // immediate rows
      endcase
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic [12:0] status, next_status; // sticky fault flags
   logic [7:0] faultStat, next_faultStat; // fault status causes
   logic [7:0] faultMask, next_faultMask; // fault-cause mask
   logic [17:0] ctrl, next_ctrl; // control fields
   logic [1:0] alertReg, next_alertReg; // vendor and fault-status alerts
   pfs_pkg::pfs_action_t lastAct, next_lastAct; // last action taken
   pfs_pkg::pfs_oc_cnt_t ocCnt, next_ocCnt; // consecutive overcurrents
   logic preBiasPend, next_preBiasPend; // command waiting on safe zero
   logic actAHold, next_actAHold; // type A effects held
   logic fetOff, next_fetOff; // shield FET off
   logic stgLock, next_stgLock; // supply disabled by short to ground
   logic closed, next_closed; // cable switch closed
   logic chgReset, next_chgReset; // charger-detect reset pulse
   logic [31:0] next_rdata;

   logic [N-1:0] raw, gate, qual, rise;
   logic retryBusy, retryStart;
   logic [LW-1:0] retryLen;
   logic clMode, sumMask, swEn;
   logic [1:0] pinMask;
   logic present;
   logic wrStatus, wrFstat, wrAlert, wrCmd, srcDefCmd, convEnCmd;
   logic ocThird, anyA, anyB, anyD, anyC, sumEv;
   logic [12:0] stSet;
   logic [7:0] fsSet;

   assign clMode = ctrl[`PFS_CT_CL_MODE];
   assign sumMask = ctrl[`PFS_CT_SUM_MASK];
   assign swEn = ctrl[`PFS_CT_SW_EN];
   assign pinMask = ctrl[`PFS_CT_PIN_HI:`PFS_CT_PIN_LO];
   assign present = qual[I_PRS];
   assign output_undervolt_level_sel = ctrl[`PFS_CT_OUV_HI:`PFS_CT_OUV_LO];
   assign input_undervolt_level_sel = ctrl[`PFS_CT_IUV_HI:`PFS_CT_IUV_LO];
   assign stgLevelHigh = clMode;

   // -----------------------------------------------------------------
   // comparator routing and qualifying gates
   // -----------------------------------------------------------------
   always_comb begin
      raw = '0;
      gate = '1;
      raw[I_OUV] = outUvCmp;
      raw[I_STG] = outStgCmp;
      raw[I_PRE] = outAboveSafe0Cmp;
      raw[I_OCL] = csOcLowCmp;
      raw[I_OCH] = csOcHighCmp;
      raw[I_CUV] = csFastUvCmp;
      raw[I_REV] = csReverseCmp;
      raw[I_PRS] = ~cfgLineLowCmp;
      raw[I_CSTG] = cfgLineLowCmp;
      raw[I_IUV] = inUvCmp;
      raw[I_SHT] = shieldThreshCmp;
      raw[I_SHS] = shieldSlopeCmp;
      raw[I_IOC] = inOcCmp;
      raw[I_RNA] = outBelowHalfCmp | outCurrentOverCmp;
      // undervolt blanking depends on the limit mode
      if (!clMode) begin
         gate[I_OUV] = ~(outOff | outSoftStart | outTransition);
      end else if (!in_current_limit_regulation) begin
         gate[I_OUV] = ~(outOff | outSoftStart);
      end else begin
         gate[I_OUV] = 1'b0;
      end
      gate[I_PRE] = preBiasPend;
      // overcurrent only means something while the switch carries current
      gate[I_OCL] = closed;
      gate[I_OCH] = closed;
      // short check runs before soft-start, while the line is not present
      gate[I_CSTG] = swEn & ~present & ~stgLock;
   end

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_deb
         pfs_debounce #(
            .CYC(deb_cyc(gi)),
            .SYNC(1'b1),
            .CW(18)
         ) u_deb (
            .ref_clk(ref_clk),
            .rst(rst),
            .raw(raw[gi]),
            .gate(gate[gi]),
            .qual(qual[gi]),
            .rise(rise[gi])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // fault events: flags, fault status and action type
   // -----------------------------------------------------------------
   always_comb begin
      stSet = '0;
      fsSet = '0;
      next_ocCnt = ocCnt;
      ocThird = 1'b0;
      // consecutive count of cable overcurrents
      if (!swEn) begin
         next_ocCnt = pfs_pkg::OC_NONE;
      end else if (rise[I_OCL] | rise[I_OCH]) begin
         case (ocCnt)
            pfs_pkg::OC_NONE: next_ocCnt = pfs_pkg::OC_ONE;
            pfs_pkg::OC_ONE: next_ocCnt = pfs_pkg::OC_TWO;
            pfs_pkg::OC_TWO: begin
               next_ocCnt = pfs_pkg::OC_NONE;
               ocThird = 1'b1;
            end
            default: next_ocCnt = pfs_pkg::OC_NONE;
         endcase
      end
      stSet[`PFS_ST_OUT_UV] = rise[I_OUV];
      stSet[`PFS_ST_OUT_STG] = rise[I_STG];
      stSet[`PFS_ST_HOST_ERR] = rise[I_PRE];
      fsSet[`PFS_FS_HOST_ERR] = rise[I_PRE];
      stSet[`PFS_ST_CS_OCL] = (ocThird & rise[I_OCL]) | (rise[I_CUV] & swEn);
      stSet[`PFS_ST_CS_OCF] = ocThird | (rise[I_CUV] & swEn);
      fsSet[`PFS_FS_CS_OCF] = ocThird | (rise[I_CUV] & swEn);
      stSet[`PFS_ST_CS_UV] = rise[I_CUV];
      stSet[`PFS_ST_CS_REV] = rise[I_REV];
      stSet[`PFS_ST_INPUT_UNDERVOLT_FLAG] = rise[I_IUV];
      stSet[`PFS_ST_SHIELD] = rise[I_SHT] | rise[I_SHS];
      stSet[`PFS_ST_INPUT_OVERCURRENT_FLAG] = rise[I_IOC];
      stSet[`PFS_ST_RUNAWAY] = rise[I_RNA];
      sumEv = rise[I_OUV] | rise[I_STG] | (ocThird & rise[I_OCL]) | (rise[I_CUV] & swEn)
         | rise[I_REV] | rise[I_IUV] | rise[I_SHT] | rise[I_SHS] | rise[I_IOC]
         | rise[I_RNA];
      stSet[`PFS_ST_SUMMARY] = sumEv;
      stSet[`PFS_ST_VENDOR] = sumEv & sumMask;
      anyA = rise[I_STG] | rise[I_IUV] | rise[I_SHT] | rise[I_SHS] | rise[I_RNA];
      anyB = rise[I_OCL] | rise[I_OCH] | rise[I_CUV];
      anyC = rise[I_OUV] | rise[I_PRE] | rise[I_IOC];
      anyD = rise[I_REV] | rise[I_CSTG];
      // most severe action wins the record
      if (anyA) begin
         next_lastAct = pfs_pkg::ACT_A;
      end else if (anyD) begin
         next_lastAct = pfs_pkg::ACT_D;
      end else if (anyB) begin
         next_lastAct = pfs_pkg::ACT_B;
      end else if (anyC) begin
         next_lastAct = pfs_pkg::ACT_C;
      end else begin
         next_lastAct = lastAct;
      end
   end

   // -----------------------------------------------------------------
   // cable switch retry and the held action outputs
   // -----------------------------------------------------------------
   always_comb begin
      retryStart = anyA | anyB | anyD;
      // the 16ms short-to-ground retry overrides the programmed time
      if (rise[I_CSTG]) begin
         retryLen = LW'(STG_RETRY_CYC);
      end else if (anyA | anyD | ocThird) begin
         retryLen = LW'((int'(ctrl[`PFS_CT_RTY_HI:`PFS_CT_RTY_LO]) + 1) * RETRY_UNIT_CYC);
      end else begin
         retryLen = LW'(B_RETRY_CYC);
      end
      // type A holds until software re-enables the converter
      next_actAHold = anyA | (actAHold & ~convEnCmd);
      next_fetOff = (rise[I_SHT] | rise[I_SHS]) | (fetOff & ~convEnCmd);
      next_chgReset = anyA;
      next_stgLock = swEn & (stgLock | rise[I_CSTG]);
      // recovery recloses only by the enable and only once the line is present
      next_closed = swEn & present & ~retryBusy & ~retryStart & ~next_stgLock;
      next_preBiasPend = (srcDefCmd & ~preBiasPend) | (preBiasPend & qual[I_PRE] & ~rise[I_PRE])
         | (preBiasPend & ~qual[I_PRE] & outAboveSafe0Cmp & ~rise[I_PRE]);
   end

   pfs_retry #(
      .LW(LW)
   ) u_retry (
      .ref_clk(ref_clk),
      .rst(rst),
      .start(retryStart),
      .len(retryLen),
      .busy(retryBusy)
   );

   // -----------------------------------------------------------------
   // register port: writes, clears and read data
   // -----------------------------------------------------------------
   always_comb begin
      wrStatus = wr & (addr == `PFS_OFS_STATUS);
      wrFstat = wr & (addr == `PFS_OFS_FSTAT);
      wrAlert = wr & (addr == `PFS_OFS_ALERT);
      wrCmd = wr & (addr == `PFS_OFS_CMD);
      srcDefCmd = wrCmd & wdata[`PFS_CMD_SRC_DEF];
      convEnCmd = wrCmd & wdata[`PFS_CMD_CONV_EN];
      // write one to clear; a set in the same cycle wins
      next_status = (status & ~(wrStatus ? wdata[12:0] : 13'h0000)) | stSet;
      next_faultStat = (faultStat & ~(wrFstat ? wdata[7:0] : 8'h00)) | fsSet;
      next_faultMask = (wr && addr == `PFS_OFS_FMASK) ? wdata[7:0] : faultMask;
      next_ctrl = (wr && addr == `PFS_OFS_CTRL) ? wdata[17:0] : ctrl;
      next_alertReg = alertReg & ~(wrAlert ? wdata[1:0] : 2'h0);
      next_alertReg[`PFS_AL_VENDOR] = next_alertReg[`PFS_AL_VENDOR] | (sumEv & sumMask);
      next_alertReg[`PFS_AL_FSTAT] = next_alertReg[`PFS_AL_FSTAT]
         | (|(fsSet & faultMask));
      next_rdata = 32'h0000_0000;
      if (rd) begin
         case (addr)
            `PFS_OFS_STATUS: next_rdata = {19'h00000, status};
            `PFS_OFS_FSTAT: next_rdata = {24'h000000, faultStat};
            `PFS_OFS_FMASK: next_rdata = {24'h000000, faultMask};
            `PFS_OFS_CTRL: next_rdata = {14'h0000, ctrl};
            `PFS_OFS_ALERT: begin
               next_rdata[1:0] = alertReg;
               next_rdata[`PFS_AL_PRESENT] = present;
               next_rdata[`PFS_AL_CLOSED] = closed;
               next_rdata[`PFS_AL_RETRY] = retryBusy;
               next_rdata[`PFS_AL_ACT_HI:`PFS_AL_ACT_LO] = lastAct;
            end
            default: next_rdata = 32'h0000_0000; // unmapped and command read zero
         endcase
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status <= '0;
         faultStat <= '0;
         faultMask <= `PFS_RST_FMASK;
         ctrl <= `PFS_RST_CTRL;
         alertReg <= '0;
         lastAct <= pfs_pkg::ACT_NONE;
         ocCnt <= pfs_pkg::OC_NONE;
         preBiasPend <= 1'b0;
         actAHold <= 1'b0;
         fetOff <= 1'b0;
         stgLock <= 1'b0;
         closed <= 1'b0;
         chgReset <= 1'b0;
         rdata <= '0;
      end else begin
         status <= next_status;
         faultStat <= next_faultStat;
         faultMask <= next_faultMask;
         ctrl <= next_ctrl;
         alertReg <= next_alertReg;
         lastAct <= next_lastAct;
         ocCnt <= next_ocCnt;
         preBiasPend <= next_preBiasPend;
         actAHold <= next_actAHold;
         fetOff <= next_fetOff;
         stgLock <= next_stgLock;
         closed <= next_closed;
         chgReset <= next_chgReset;
         rdata <= next_rdata;
      end
   end

   // -----------------------------------------------------------------
   // outputs; type C touches none of these but the alert pin
   // -----------------------------------------------------------------
   assign convDisable = actAHold;
   assign dataSwitchOpen = actAHold;
   assign passSwitchOpen = actAHold;
   assign cfgLineDischarge = actAHold;
   assign chargerDetReset = chgReset;
   assign shieldFetOff = fetOff;
   assign cableSwitchClose = closed;
   assign alertN_out = 1'b0;
   // masked alerts stay readable but release the pin
   assign alertN_oe = ~(|(alertReg & pinMask));
endmodule

// File: test/pfs_top_checker.sv
// port assertions of the protection fault supervisor and their bind
module pfs_top_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic stgLevelHigh,
   input wire logic [2:0] output_undervolt_level_sel,
   input wire logic convDisable,
   input wire logic passSwitchOpen,
   input wire logic chargerDetReset,
   input wire logic cableSwitchClose,
   input wire logic alertN_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] lastW; // write data of the previous cycle, for one-cycle-late compares
   always_ff @(posedge ref_clk) begin
      lastW <= wdata;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
   a_cmd_reads_zero: assert property (rd && addr == 8'h14 |=> rdata == 32'h0)
      else $error("command word read back");
   a_cl_level: assert property (wr && addr == 8'h0c |=> stgLevelHigh == lastW[0])
      else $error("short level not from mode");
   a_uv_sel: assert property (wr && addr == 8'h0c |=> output_undervolt_level_sel == lastW[6:4])
      else $error("undervolt select wrong");
   a_pin_low: assert property (alertN_out == 1'b0) else $error("alert pin drives high");
   a_chg_pulse: assert property (chargerDetReset |=> !chargerDetReset)
      else $error("charger reset too long");
   a_sw_group: assert property (convDisable == passSwitchOpen) else $error("type A split");
   a_a_opens_sw: assert property ($rose(convDisable) |-> ##[0:2] !cableSwitchClose)
      else $error("cable switch kept closed");
endmodule
bind pfs_top pfs_top_checker pfs_top_checker_i (.*);

// File: test/pfs_host_model.sv
// port manager side of the alert line: pull-up resolves the open-drain pin
module pfs_host_model (
   input wire logic alertN_out,
   input wire logic alertN_oe,
   output logic alertWire
);
   timeunit 1ns;
   timeprecision 1ns;
   // a released pin floats to the pull-up level
   assign alertWire = alertN_oe ? 1'b1 : alertN_out;
endmodule

// File: test/test_protection_fault_supervisor.sv
// bench of the protection fault supervisor: stimulus, reference values and verdict
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_protection_fault_supervisor;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = '0, rst = '1, wr = '0, rd = '0;
   logic [7:0] addr = '0;
   logic [31:0] wdata = '0, rdata, seed = 32'h8a2e69da;
   logic outUvCmp = '0, outStgCmp = '0, outAboveSafe0Cmp = '0, csOcLowCmp = '0;
   logic csOcHighCmp = '0, csFastUvCmp = '0, csReverseCmp = '0, cfgLineLowCmp = '0;
   logic inUvCmp = '0, shieldThreshCmp = '0, shieldSlopeCmp = '0, inOcCmp = '0;
   logic outBelowHalfCmp = '0, outCurrentOverCmp = '0, outOff = '0, outSoftStart = '0;
   logic outTransition = '0, in_current_limit_regulation = '0;
   logic [2:0] output_undervolt_level_sel;
   logic [3:0] input_undervolt_level_sel;
   logic stgLevelHigh, convDisable, dataSwitchOpen, passSwitchOpen, cfgLineDischarge;
   logic chargerDetReset, shieldFetOff, cableSwitchClose, alertN_out, alertN_oe, alertWire;
   int miscompares = 0, total_checks = 0, ocN;
   pfs_top #(.OUT_UV_DEB_CYC(40), .INPUT_OVERCURRENT_FLAG_DEB_CYC(40), .STG_LOW_CYC(30), .STG_RETRY_CYC(40),
      .RETRY_UNIT_CYC(10), .B_RETRY_CYC(10)) pfs_top_i (.*);
   pfs_host_model pfs_host_model_i (.*);
   always #50 ref_clk = ~ref_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // one-cycle write strobe beside address and data
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= '1;
      @(posedge ref_clk);
      wr <= '0;
   endtask
   // read strobe, then compare the masked answer in the following cycle
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, e);
      @(posedge ref_clk);
      addr <= a;
      rd <= '1;
      @(posedge ref_clk);
      rd <= '0;
      #1 `CHK(n, e, rdata & m)
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      cyc(6);
      rst <= '0;
      rchk("ctrl", 8'h0c, '1, 32'h30002);
      rchk("fmask", 8'h08, '1, 32'hff);
      rchk("status", 8'h00, '1, 32'h0);
      seed = lfsr(seed);
      wreg(8'h0c, seed);
      rchk("ctrl rw", 8'h0c, '1, seed & 32'h3ffff);
      wreg(8'h0c, 32'h30002);
      rchk("cmd", 8'h14, '1, 32'h0);
      rchk("gap", 8'h20, '1, 32'h0);
      // a condition dropped early must restart the timer
      repeat (2) begin
         inUvCmp <= '1;
         cyc(600);
         inUvCmp <= '0;
         cyc(20);
      end
      rchk("uv chop", 8'h00, '1, 32'h0);
      inUvCmp <= '1;
      cyc(1020);
      rchk("uv", 8'h00, '1, 32'h1880);
      `CHK("conv off", 1'b1, convDisable)
      `CHK("pin low", 1'b0, alertWire)
      rchk("act", 8'h10, 32'h7003, 32'h1001);
      inUvCmp <= '0;
      wreg(8'h0c, 32'h2);
      rchk("alert kept", 8'h10, 32'h1, 32'h1);
      `CHK("pin masked", 1'b1, alertWire)
      wreg(8'h00, 32'h1fff);
      wreg(8'h10, 32'h3);
      wreg(8'h14, 32'h2);
      cyc(2);
      `CHK("conv on", 1'b0, convDisable)
      wreg(8'h0c, 32'h0);
      outBelowHalfCmp <= '1;
      cyc(10);
      rchk("runaway", 8'h00, '1, 32'h0c00);
      rchk("no vendor", 8'h10, 32'h1, 32'h0);
      outBelowHalfCmp <= '0;
      wreg(8'h00, 32'h1fff);
      wreg(8'h14, 32'h2);
      wreg(8'h0c, 32'h30006);
      cyc(400);
      `CHK("closed", 1'b1, cableSwitchClose)
      // flags only on the third consecutive overcurrent
      for (ocN = 1; ocN <= 3; ocN++) begin
         csOcHighCmp <= '1;
         cyc(70);
         csOcHighCmp <= '0;
         cyc(100);
         rchk("ocf", 8'h00, 32'h10, (ocN == 3) ? 32'h10 : 32'h0);
      end
      rchk("fstat", 8'h04, '1, 32'h2);
      // limit mode: regulation, off and soft-start blank undervolt, transitions do not
      wreg(8'h0c, 32'h30003);
      in_current_limit_regulation <= '1;
      outUvCmp <= '1;
      cyc(60);
      rchk("uv reg", 8'h00, 32'h1, 32'h0);
      in_current_limit_regulation <= '0;
      outOff <= '1;
      outSoftStart <= '1;
      cyc(60);
      rchk("uv off", 8'h00, 32'h1, 32'h0);
      outOff <= '0;
      outSoftStart <= '0;
      outTransition <= '1;
      cyc(60);
      rchk("uv trans", 8'h00, 32'h1, 32'h1);
      outUvCmp <= '0;
      // several fault rows at once: each sets its flag, the two shield rows share one
      {outStgCmp, csReverseCmp, shieldThreshCmp} <= '1;
      {shieldSlopeCmp, inOcCmp, outCurrentOverCmp} <= '1;
      cyc(70);
      rchk("rows", 8'h00, 32'h742, 32'h742);
      report_and_stop();
   end
endmodule
